// ### logic/asc_conv_clk.sv
// module: conversion clock enable divider with rc and sleep handling
`timescale 1ns/10ps
`default_nettype none
module asc_conv_clk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] clk_sel,
  input wire logic run,
  input wire logic rc_tick,
  input wire logic sleeping,
  output var logic conv_tick
);
  import asc_pkg::*;
  logic [4:0] div_cnt_reg; // oscillator cycles in this period
  logic [4:0] div_last; // terminal count for the chosen ratio

  // terminal count from the select code
  always_comb begin
    case (clk_sel)
      CLKSEL_DIV2: div_last = DIV2_LAST;
      CLKSEL_DIV8: div_last = DIV8_LAST;
      default: div_last = DIV32_LAST;
    endcase
  end

  // one-cycle tick per conversion clock period; idle when not converting
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_cnt_reg <= 5'h00;
      conv_tick <= 1'b0;
    end else if (clk_sel == CLKSEL_RC) begin
      div_cnt_reg <= 5'h00;
      conv_tick <= rc_tick; // rc keeps running in sleep
    end else if (sleeping) begin
      conv_tick <= 1'b0; // oscillator stopped: conversion stalls
    end else if (div_cnt_reg == div_last) begin
      div_cnt_reg <= 5'h00;
      conv_tick <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
      conv_tick <= 1'b0;
    end
  end

  AST_DIV2_SPACING: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_tick && clk_sel == CLKSEL_DIV2 && $stable(clk_sel)) |=> !conv_tick)
    else $error("divide-by-two tick came back to back");
  AST_SLEEP_HALTS: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleeping && clk_sel != CLKSEL_RC && $stable(clk_sel)) |=> !conv_tick)
    else $error("oscillator clock ticked during sleep");
endmodule
`default_nettype wire

// ### logic/asc_pkg.sv
// package: register map, field layout, counts and carrier types of the sar converter control
// Overview of operation
// - three-bit select picks channels zero to four
// - successive approximation yields eight-bit result
// - reference is supply or reference pin
// - converts asleep only on internal rc clock
// - reset clears registers, powers off, aborts
// - top two bits pick conversion clock
// - writing go starts; hardware clears when done
// - control bit one reads zero
// - control register index 1f, resets zero
// - result, control and pin configuration registers
// - pin configuration: analog or digital, reference
// - channels share port pins; channel three reference
package asc_pkg;
  localparam int RES_BITS = 8; // converter resolution
  localparam int NUM_CHAN = 5; // selectable channels
  localparam int VREF_PIN = 3; // analog pin that may carry the reference
  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_RESULT = 6'h1e;
  localparam logic [5:0] IDX_CTRL = 6'h1f;
  localparam logic [5:0] IDX_PINCFG = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h21;
  localparam logic [5:0] IDX_MASK = 6'h22;
  // conversion clock select codes
  localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
  localparam logic [1:0] CLKSEL_DIV8 = 2'h1;
  localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
  localparam logic [1:0] CLKSEL_RC = 2'h3;
  // last divider count for each oscillator ratio
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  // reset values and masks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RD_MASK = 8'hfd;
  localparam logic [5:0] PINCFG_RESET = 6'h00;
  localparam logic [1:0] EVENT_RESET = 2'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] SAR_MSB_TRIAL = 8'h80;
  // event bit positions in status and mask
  localparam int EV_DONE = 0;
  localparam int EV_REFUSED = 1;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // main control register layout
  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic go;
    logic unused;
    logic power;
  } asc_ctrl_t;
  // pin configuration register layout
  typedef struct packed {
    logic vref_ext;
    logic [4:0] analog_en;
  } asc_pincfg_t;
  // everything the analog macro needs from the control logic
  typedef struct packed {
    logic [7:0] dac_code;
    logic hold;
    logic [4:0] chan_en;
    logic [4:0] pin_en;
    logic ref_ext;
    logic power;
  } asc_analog_t;
endpackage

// ### logic/asc_sar.sv
// module: successive approximation sequencer with sample and hold control
`timescale 1ns/10ps
`default_nettype none
module asc_sar (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_tick,
  input wire logic start,
  input wire logic abort,
  input wire logic cmp_above,
  output var logic busy,
  output var logic done,
  output var logic [7:0] result,
  output var logic [7:0] dac_code,
  output var logic hold
);
  import asc_pkg::*;
  typedef enum logic [1:0] {SAR_IDLE, SAR_SETTLE, SAR_DECIDE} asc_sar_state_t;
  asc_sar_state_t state_reg; // sequencer state
  logic [2:0] bit_idx_reg; // bit under trial

  assign busy = (state_reg != SAR_IDLE);

  // each bit takes two conversion ticks: one to settle the dac and
  // comparator path through its synchroniser, one to decide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SAR_IDLE;
      bit_idx_reg <= 3'h7;
      dac_code <= 8'h00;
      hold <= 1'b0;
      done <= 1'b0;
      result <= RESULT_RESET;
    end else if (abort) begin // power off drops the conversion
      state_reg <= SAR_IDLE;
      hold <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        SAR_IDLE: begin
          if (start) begin // hold the sample, try the msb
            state_reg <= SAR_SETTLE;
            bit_idx_reg <= 3'(RES_BITS - 1);
            dac_code <= SAR_MSB_TRIAL;
            hold <= 1'b1;
          end
        end
        SAR_SETTLE: begin
          if (conv_tick) begin
            state_reg <= SAR_DECIDE;
          end
        end
        SAR_DECIDE: begin
          if (conv_tick) begin // keep the bit if input is at or above trial
            if (bit_idx_reg == 3'h0) begin
              result <= {dac_code[7:1], cmp_above};
              done <= 1'b1;
              hold <= 1'b0;
              state_reg <= SAR_IDLE;
            end else begin
              dac_code[bit_idx_reg] <= cmp_above;
              dac_code[bit_idx_reg - 3'h1] <= 1'b1;
              bit_idx_reg <= bit_idx_reg - 3'h1;
              state_reg <= SAR_SETTLE;
            end
          end
        end
        default: state_reg <= SAR_IDLE;
      endcase
    end
  end

  AST_START_TRIAL: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == SAR_IDLE && start && !abort) |=> (dac_code == SAR_MSB_TRIAL && hold))
    else $error("conversion did not open with the msb trial");
  AST_DONE_FROM_LSB: assert property (@(posedge aclk) disable iff (!aresetn)
    done |-> ($past(bit_idx_reg) == 3'h0 && $past(state_reg) == SAR_DECIDE && !hold))
    else $error("done raised before the last bit was decided");
endmodule
`default_nettype wire

// ### logic/asc_top.sv
// module: sar converter control with axi4-lite registers and interrupt
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module asc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_above,
  input wire logic internal_rc_clock,
  input wire logic sleep_req,
  output var asc_pkg::asc_analog_t analog_out,
  output var logic irq
);
  import asc_pkg::*;

  // synchronised pins: bit0 comparator, bit1 rc oscillator, bit2 sleep
  logic [2:0] pin_meta_reg; // first stage, read by second stage only
  logic [2:0] pin_sync_reg; // safe copies
  logic rc_last_reg; // previous rc level for edge detect
  logic rc_tick; // one pulse per rc rising edge

  // bus write side
  logic [5:0] wr_idx_reg; // captured write index
  logic wr_align_reg; // captured address was word aligned
  logic [7:0] wr_data_reg; // low byte of write data
  logic wr_strb_reg; // low byte lane enabled
  logic wr_fire; // address and data both held, answer free
  logic wr_ok; // write hits a mapped register
  logic wr_lane; // write reaches the low byte of a mapped register
  asc_ctrl_t wr_ctrl_val; // write data seen as control layout

  // bus read side
  logic [5:0] rd_idx_reg; // index of the last read
  logic [31:0] rd_val; // read mux
  logic rd_ok; // read hits a mapped register

  // registers
  asc_ctrl_t ctrl_reg; // main converter control
  asc_pincfg_t pin_cfg_reg; // pin function configuration
  logic [7:0] result_reg; // last conversion result
  logic [1:0] status_reg; // sticky events
  logic [1:0] mask_reg; // event enables
  logic [1:0] ev_set; // events this cycle
  logic [1:0] ev_clr; // write-one-to-clear this cycle

  // derived outputs, all flops
  logic [4:0] chan_en_reg; // one-hot selected channel
  logic [4:0] pin_en_reg; // pins switched to analog
  logic ref_ext_reg; // reference from the pin

  // converter core hookup
  logic start_ok; // honoured start request
  logic start_refused; // start written while powered off
  logic conv_tick; // conversion clock enable
  logic sar_busy;
  logic sar_done;
  logic sar_hold;
  logic [7:0] sar_result;
  logic [7:0] sar_dac;

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx >= IDX_RESULT) && (idx <= IDX_MASK);
  endfunction

  // two-flop synchronisers for everything arriving from the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {sleep_req, internal_rc_clock, comparator_above};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // rising edge of the rc oscillator, after synchronisation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_last_reg <= 1'b0;
    end else begin
      rc_last_reg <= pin_sync_reg[1];
    end
  end
  assign rc_tick = pin_sync_reg[1] & ~rc_last_reg;

  // write address channel: take once, reopen after the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      wr_idx_reg <= 6'h00;
      wr_align_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_idx_reg <= s_axi_awaddr[7:2];
      wr_align_reg <= (s_axi_awaddr[1:0] == 2'h0);
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel: independent of the address, either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wr_data_reg <= 8'h00;
      wr_strb_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data_reg <= s_axi_wdata[7:0];
      wr_strb_reg <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok = wr_align_reg && idx_mapped(wr_idx_reg);
  assign wr_lane = wr_fire && wr_ok && wr_strb_reg;
  assign wr_ctrl_val = asc_ctrl_t'(wr_data_reg);

  // write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // start only from a powered, idle converter; a repeat while busy is dropped
  assign start_ok = wr_lane && (wr_idx_reg == IDX_CTRL) && wr_ctrl_val.go
    && ctrl_reg.power && !ctrl_reg.go;
  assign start_refused = wr_lane && (wr_idx_reg == IDX_CTRL) && wr_ctrl_val.go
    && !ctrl_reg.power;

  // main control register; bit one is never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= asc_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_lane && wr_idx_reg == IDX_CTRL) begin
        ctrl_reg.clk_sel <= wr_ctrl_val.clk_sel;
        ctrl_reg.chan <= wr_ctrl_val.chan;
        ctrl_reg.power <= wr_ctrl_val.power;
      end
      // the start wins; hardware clears on completion or power loss
      if (start_ok) begin
        ctrl_reg.go <= 1'b1;
      end else if (sar_done || !ctrl_reg.power) begin
        ctrl_reg.go <= 1'b0;
      end
    end
  end

  // pin configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cfg_reg <= asc_pincfg_t'(PINCFG_RESET);
    end else if (wr_lane && wr_idx_reg == IDX_PINCFG) begin
      pin_cfg_reg <= asc_pincfg_t'(wr_data_reg[5:0]);
    end
  end

  // result lands on the edge that clears the go bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= RESULT_RESET;
    end else if (sar_done) begin
      result_reg <= sar_result;
    end
  end

  // sticky events: a new event beats a clear in the same cycle
  assign ev_set = {start_refused, sar_done};
  assign ev_clr = (wr_lane && wr_idx_reg == IDX_STATUS) ? wr_data_reg[1:0] : 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= EVENT_RESET;
    end else begin
      status_reg <= (status_reg & ~ev_clr) | ev_set;
    end
  end

  // event mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= EVENT_RESET;
    end else if (wr_lane && wr_idx_reg == IDX_MASK) begin
      mask_reg <= wr_data_reg[1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // read mux; result is read-only and unmapped words read zero
  always_comb begin
    rd_ok = (s_axi_araddr[1:0] == 2'h0) && idx_mapped(s_axi_araddr[7:2]);
    case (s_axi_araddr[7:2])
      IDX_RESULT: rd_val = {24'h0, result_reg};
      IDX_CTRL: rd_val = {24'h0, 8'(ctrl_reg) & CTRL_RD_MASK};
      IDX_PINCFG: rd_val = {26'h0, 6'(pin_cfg_reg)};
      IDX_STATUS: rd_val = {30'h0, status_reg};
      IDX_MASK: rd_val = {30'h0, mask_reg};
      default: rd_val = 32'h0;
    endcase
    if (!rd_ok) begin
      rd_val = 32'h0;
    end
  end

  // read channel: answer the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      rd_idx_reg <= 6'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
      rd_idx_reg <= s_axi_araddr[7:2];
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // per-pin decode: channel one-hot and analog pin functions
  generate
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          chan_en_reg[g] <= 1'b0;
          pin_en_reg[g] <= 1'b0;
        end else begin
          // codes five to seven select nothing
          chan_en_reg[g] <= (ctrl_reg.chan == 3'(g));
          // the channel three pin turns analog when it carries the reference
          pin_en_reg[g] <= pin_cfg_reg.analog_en[g]
            | ((g == VREF_PIN) && pin_cfg_reg.vref_ext);
        end
      end
    end
  endgenerate

  // reference source select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_ext_reg <= 1'b0;
    end else begin
      ref_ext_reg <= pin_cfg_reg.vref_ext;
    end
  end

  // conversion clock; sleep only stalls the oscillator-derived ratios
  asc_conv_clk u_conv_clk (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(ctrl_reg.clk_sel),
    .run(sar_busy),
    .rc_tick(rc_tick),
    .sleeping(pin_sync_reg[2]),
    .conv_tick(conv_tick)
  );

  // approximation engine; losing power abandons the conversion
  asc_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .conv_tick(conv_tick),
    .start(start_ok),
    .abort(!ctrl_reg.power),
    .cmp_above(pin_sync_reg[0]),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result),
    .dac_code(sar_dac),
    .hold(sar_hold)
  );

  // analog macro controls, straight from flops
  assign analog_out.dac_code = sar_dac;
  assign analog_out.hold = sar_hold;
  assign analog_out.chan_en = chan_en_reg;
  assign analog_out.pin_en = pin_en_reg;
  assign analog_out.ref_ext = ref_ext_reg;
  assign analog_out.power = ctrl_reg.power; // no operating current when low

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CTRL_BIT1_ZERO: assert property (
    (s_axi_rvalid && rd_idx_reg == IDX_CTRL && s_axi_rresp == RESP_OKAY) |-> !s_axi_rdata[1])
    else $error("control bit one read back as one");
  AST_RESULT_WITH_CLEAR: assert property (
    sar_done |=> (!ctrl_reg.go && result_reg == $past(sar_result)))
    else $error("result and status clear did not coincide");
  AST_START_NEEDS_POWER: assert property (
    $rose(sar_busy) |-> ($past(ctrl_reg.power) && ctrl_reg.go))
    else $error("conversion began without power");
  AST_OFF_ABORTS: assert property (
    !ctrl_reg.power |=> (!sar_busy && !ctrl_reg.go))
    else $error("conversion survived power off");
  AST_GO_COVERS_BUSY: assert property (
    sar_busy |-> ctrl_reg.go)
    else $error("go bit low while converting");
  AST_GO_STARTS: assert property (
    start_ok |=> (sar_busy && ctrl_reg.go) [*2])
    else $error("start request did not begin a conversion");
  AST_CHAN_DECODE: assert property (
    1'b1 |=> (chan_en_reg == (($past(ctrl_reg.chan) < 3'h5) ? 5'(5'h01 << $past(ctrl_reg.chan)) : 5'h00)))
    else $error("channel decode wrong");
  AST_REF_PIN: assert property (
    pin_cfg_reg.vref_ext |=> (ref_ext_reg && pin_en_reg[VREF_PIN]))
    else $error("reference pin not switched over");
  AST_IRQ_LEVEL: assert property (
    (|(status_reg & mask_reg)) |=> irq)
    else $error("interrupt missing for unmasked event");
  AST_REFUSED_FLAGGED: assert property (
    start_refused |=> (status_reg[EV_REFUSED] && !sar_busy))
    else $error("unpowered start not flagged");

  CVR_DONE: cover property (sar_done ##1 irq);
  CVR_REFUSED: cover property (start_refused);
  CVR_DECERR: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
  CVR_RC_SLEEP: cover property (pin_sync_reg[2] && ctrl_reg.clk_sel == CLKSEL_RC && sar_done);
endmodule
`default_nettype wire

// ### tb/asc_analog_src.sv
// partner model: analog sources behind the five channels and the internal rc oscillator
`timescale 1ns/10ps
`default_nettype none
module asc_analog_src (
  input wire asc_pkg::asc_analog_t aout,
  output var logic cmp,
  output var logic rc
);
  import asc_pkg::*;
  logic [7:0] lvl; // level of the selected source
  // comparator: above while the held level reaches the trial code
  always_comb begin
    lvl = 8'h00;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (aout.chan_en[i]) begin
        lvl = 8'h17 + 8'(8'h2d * i); // one fixed level per channel
      end
    end
    cmp = (lvl >= aout.dac_code); // trial decision for the sar
  end
  // rc oscillator runs free, in no phase relation to the bus clock
  initial rc = 1'b0;
  always #19 rc = ~rc; // keeps running while asleep
endmodule
`default_nettype wire

// ### tb/testbench.sv
// testbench: register, conversion, interrupt and reset scenarios of the converter control
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import asc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0; // active low
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sleep_req = 1'b0; // device asleep when high
  logic [3:0] wstrb = 4'hf; // byte lanes offered with each write
  wire logic awready, wready, bvalid, arready, rvalid, cmp, rc, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire asc_analog_t aout;
  logic [31:0] rd_d; // last read word
  logic [1:0] resp; // last response code
  int fails = 0, compares = 0;
  always #2.5 aclk = ~aclk;
  asc_top i_asc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_above(cmp),
    .internal_rc_clock(rc), .sleep_req(sleep_req), .analog_out(aout), .irq(irq));
  asc_analog_src i_asc_analog_src (.aout(aout), .cmp(cmp), .rc(rc));
  task automatic close_out;
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic to;
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ta, tw;
    n = 0; ta = 0; tw = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !ta) begin ta = 1; awvalid <= 1'b0; end
      if (wready === 1'b1 && !tw) begin tw = 1; wvalid <= 1'b0; end
      if (++n > 100) to();
    end
    do begin @(posedge aclk); if (++n > 200) to(); end while (bvalid !== 1'b1);
    resp = bresp; bready <= 1'b0;
    @(posedge aclk); // spacing so no strobe is driven twice in one step
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(posedge aclk); if (++n > 100) to(); end while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) begin @(posedge aclk); if (++n > 200) to(); end
    rd_d = rdata; resp = rresp; rready <= 1'b0;
    @(posedge aclk);
  endtask
  function automatic logic [31:0] lvl(input int c);
    return 32'(8'h17 + 8'(8'h2d * c));
  endfunction
  // power up with clock and channel, wait for acquisition, then start
  task automatic go(input logic [1:0] cs, input logic [2:0] ch);
    wr(8'h7c, 32'({cs, ch, 3'b001}));
    repeat (20) @(posedge aclk); // acquisition wait
    wr(8'h7c, 32'({cs, ch, 3'b101}));
  endtask
  // poll the go bit until it clears, then read the result
  task automatic fin(input int ch);
    int n;
    n = 0;
    do begin rd(8'h7c); if (++n > 400) to(); end while (rd_d[2] !== 1'b0);
    rd(8'h78); chk(rd_d, lvl(ch));
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) begin rd(8'h78 + 8'(4 * i)); chk(rd_d, 32'h0); end
    rd(8'h8c); chk(32'(resp), 32'(RESP_DECERR));
    rd(8'h7d); chk(32'(resp), 32'(RESP_DECERR));
    wr(8'h8c, 32'h1); chk(32'(resp), 32'(RESP_DECERR));
    wr(8'h78, 32'h55); chk(32'(resp), 32'(RESP_OKAY));
    rd(8'h78); chk(rd_d, 32'h0);
    wr(8'h7c, 32'hff); rd(8'h7c); chk(rd_d, 32'hf9);
    // a write without the low byte lane must leave the control register alone
    wstrb <= 4'he; wr(8'h7c, 32'h0); wstrb <= 4'hf;
    rd(8'h7c); chk(rd_d, 32'hf9);
    rd(8'h84); chk(rd_d, 32'h2);
    chk(32'(irq), 32'h0); wr(8'h88, 32'h2); chk(32'(irq), 32'h1); // masked then unmasked
    wr(8'h84, 32'h2); chk(32'(irq), 32'h0); // write one clears
    for (int c = 0; c < 5; c++) begin
      wr(8'h7c, 32'({2'b00, 3'(c), 3'b001})); chk(32'(aout.chan_en), 32'(1 << c));
    end
    wr(8'h7c, 32'h29); chk(32'(aout.chan_en), 32'h0);
    wr(8'h80, 32'h20); chk(32'({aout.pin_en[3], aout.ref_ext}), 32'h3);
    wr(8'h80, 32'h1f); chk(32'(aout.pin_en), 32'h1f);
    wr(8'h80, 32'h0); chk(32'(aout.ref_ext), 32'h0);
    wr(8'h88, 32'h1);
    for (int cs = 0; cs < 4; cs++) begin
      go(2'(cs), 3'(cs + 1)); fin(cs + 1);
      chk(32'(irq), 32'h1); wr(8'h84, 32'h1); chk(32'(irq), 32'h0);
    end
    sleep_req <= 1'b1;
    go(2'b00, 3'd0); repeat (100) @(posedge aclk);
    rd(8'h7c); chk(32'(rd_d[2]), 32'h1);
    chk(32'({aout.hold, aout.dac_code}), 32'h180);
    sleep_req <= 1'b0; fin(0);
    sleep_req <= 1'b1; go(2'b11, 3'd2); fin(2);
    sleep_req <= 1'b0;
    go(2'b01, 3'd3); repeat (20) @(posedge aclk);
    wr(8'h7c, 32'h58); rd(8'h7c); chk(rd_d, 32'h58);
    rd(8'h78); chk(rd_d, lvl(2));
    go(2'b10, 3'd4); repeat (30) @(posedge aclk);
    aresetn <= 1'b0; repeat (2) @(posedge aclk);
    chk(32'(aout), 32'h0);
    aresetn <= 1'b1; @(posedge aclk);
    rd(8'h7c); chk(rd_d, 32'h0);
    rd(8'h78); chk(rd_d, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
